// *** inc/ldb_defines.svh ***
// Purpose: Constants for the local data buffer datapath
// Assumes: Included by bare name from inc/
// Notes:   Command codes, register indices, field positions and reset values
`ifndef LDB_DEFINES_SVH
`define LDB_DEFINES_SVH

// Host command codes, sampled on every rising cpu clock edge
`define HC_IDLE     4'h0
`define HC_CMPSH    4'h1
`define HC_WINV     4'h5
`define HC_WGREG    4'h6
`define HC_DRVHM    4'h8
`define HC_RINV     4'h9
`define HC_RGREG    4'hA
`define HC_DRVHP    4'hC
`define HC_DRVHPOP  4'hD
`define HC_DRVMP    4'hE
`define HC_DRVMPOP  4'hF

// PCI command codes; push, forward and abort act on pci clock rising edges, drive codes are sampled as a level
`define PC_IDLE     3'h0
`define PC_PTHPSH   3'h1
`define PC_FDPTH    3'h2
`define PC_DRVP     3'h4
`define PC_DRVPOP   3'h5
`define PC_MABORT   3'h7

// Register locations as seen by software
`define IPI_VECTOR_ADDR 32'h0FC00008
`define GP_CONFIG_INDEX 8'h90

// General purpose register fields and reset values
`define GP_PARITY_EN_BIT 31
`define GP_MEM32_BIT     30
`define GP_RESET         32'h00000000
`define IPI_RESET        8'h00

`endif

// *** inc/ldb_pkg.sv ***
// Purpose: Shared types for the local data buffer datapath
// Assumes: Nothing
// Notes:   Constants live in ldb_defines.svh
package ldb_pkg;
  typedef logic [63:0] qword_type;
  typedef logic [31:0] dword_type;
  typedef enum logic {MEM_SRC_CTM, MEM_SRC_PTH} mem_src_type;
endpackage : ldb_pkg

// *** rtl/local_data_buffer_datapath.sv ***
// Purpose: Data buffer between host, memory and pci data buses
// Assumes: All inputs synchronous to sys_clk; pci_clock sampled as a level
// Notes:   Two-way pins split into in/out/oe_n; oe_n low while driving
// How it works
// - An 8-bit interprocessor vector register is written and read by host command codes.
// - A 32-bit general purpose register is written and read by host command codes.
// - Bit 31 of that register enables parity checking while bit 30 is clear, and resets to zero.
// - Bit 30 selects 32-bit memory when set, 64-bit when clear, and resets to zero.
// - With the upper select high, the upper half of the memory-bound entry drives the lower memory half.
// - The pop strobe advances the cpu-to-memory buffer pointer on each clock it is high.
// - Parity errors pull the open-drain system error line low.
// - Read data is captured while the latch enable is high and held once it falls.
// - Memory data and parity outputs are enabled while the write enable input is low.
// - The host command code is sampled on every rising cpu clock edge.
// - Pci push, forward and abort codes act on rising pci clock edges; drive codes are sampled as a level.
// - For pci writes to memory, the pci-to-host buffer feeds the memory bus.
// - For isa or dma memory reads, latched memory data drives the pci bus.
// - Host code 0001 pushes host data into the cpu-to-memory buffer and advances its rear.
`timescale 1ns/1ps
`include "ldb_defines.svh"

module local_data_buffer_datapath import ldb_pkg::*; #(
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] host_command_code,
  input wire logic [2:0] pci_command_code,
  input wire logic pci_clock,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic memory_upper_dword_select,
  input wire logic pci_upper_dword_select,
  input wire logic memory_read_latch_enable,
  input wire logic memory_buffer_pop_strobe,
  input wire logic memory_write_enable_n,
  input wire logic [63:0] host_data_in,
  output logic [63:0] host_data_out,
  output logic host_data_oe_n,
  input wire logic [63:0] memory_data_in,
  output logic [63:0] memory_data_out,
  output logic memory_data_oe_n,
  input wire logic [7:0] memory_parity_in,
  output logic [7:0] memory_parity_out,
  input wire logic [31:0] pci_ad_in,
  output logic [31:0] pci_ad_out,
  output logic pci_ad_oe_n,
  output logic system_error_out,
  output logic system_error_oe_n
);

  localparam int PW = $clog2(DEPTH);

  function automatic logic [7:0] even_parity(input qword_type d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction : even_parity

  qword_type ctm_mem_r [DEPTH];
  qword_type pth_mem_r [DEPTH];
  logic [PW-1:0] ctm_rear_r, ctm_front_r, pth_rear_r, pth_front_r;
  logic [7:0] ipi_r;
  dword_type gp_r;
  qword_type read_latch_r;
  logic [7:0] parity_latch_r;
  logic latch_en_prev_r, pci_clk_prev_r;
  logic pci_rise, pci_xfer, parity_err;
  mem_src_type mem_src;
  qword_type mem_entry, mem_drive;

  assign pci_rise = pci_clock & ~pci_clk_prev_r;
  assign pci_xfer = pci_rise & ~irdy_n & ~trdy_n;

  ////////////////////////////////////////////////////////////////////////////
  // Registers reached through host command codes

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ipi_r <= `IPI_RESET;
      gp_r <= `GP_RESET;
    end else begin
      if (host_command_code == `HC_WINV) begin
        ipi_r <= host_data_in[7:0];
      end
      if (host_command_code == `HC_WGREG) begin
        gp_r <= host_data_in[31:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cpu-to-memory write buffer

  always_ff @(posedge sys_clk) begin
    if (host_command_code == `HC_CMPSH) begin
      ctm_mem_r[ctm_rear_r] <= host_data_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctm_rear_r <= '0;
      ctm_front_r <= '0;
    end else begin
      if (host_command_code == `HC_CMPSH) begin
        ctm_rear_r <= ctm_rear_r + 1'b1;
      end
      if (memory_buffer_pop_strobe) begin
        ctm_front_r <= ctm_front_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pci-to-host buffer, filled on pci clock edges

  always_ff @(posedge sys_clk) begin
    if (pci_xfer && pci_command_code == `PC_PTHPSH) begin
      if (pci_upper_dword_select) begin
        pth_mem_r[pth_rear_r][63:32] <= pci_ad_in;
      end else begin
        pth_mem_r[pth_rear_r][31:0] <= pci_ad_in;
      end
    end else if (pci_rise && pci_command_code == `PC_MABORT) begin
      pth_mem_r[pth_rear_r] <= '1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pth_rear_r <= '0;
      pth_front_r <= '0;
      pci_clk_prev_r <= 1'b0;
    end else begin
      pci_clk_prev_r <= pci_clock;
      if ((pci_xfer && pci_command_code == `PC_PTHPSH && pci_upper_dword_select) ||
          (pci_rise && (pci_command_code == `PC_FDPTH || pci_command_code == `PC_MABORT))) begin
        pth_rear_r <= pth_rear_r + 1'b1;
      end
      if (host_command_code == `HC_DRVHPOP || host_command_code == `HC_DRVMPOP) begin
        pth_front_r <= pth_front_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory read latch and parity check

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      read_latch_r <= '0;
      parity_latch_r <= 8'h00;
      latch_en_prev_r <= 1'b0;
    end else begin
      latch_en_prev_r <= memory_read_latch_enable;
      if (memory_read_latch_enable) begin
        read_latch_r <= memory_data_in;
        parity_latch_r <= memory_parity_in;
      end
    end
  end

  // Checked only once the latch closes, so a settling bus never flags
  assign parity_err = latch_en_prev_r && !memory_read_latch_enable &&
                      gp_r[`GP_PARITY_EN_BIT] && !gp_r[`GP_MEM32_BIT] &&
                      (even_parity(read_latch_r) != parity_latch_r);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      system_error_oe_n <= 1'b1;
      system_error_out <= 1'b0;
    end else begin
      system_error_oe_n <= ~parity_err;
      system_error_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory bus drive

  assign mem_src = (host_command_code == `HC_DRVMP || host_command_code == `HC_DRVMPOP) ?
                   MEM_SRC_PTH : MEM_SRC_CTM;
  assign mem_entry = (mem_src == MEM_SRC_PTH) ? pth_mem_r[pth_front_r] : ctm_mem_r[ctm_front_r];
  assign mem_drive = memory_upper_dword_select ? {mem_entry[63:32], mem_entry[63:32]} : mem_entry;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memory_data_oe_n <= 1'b1;
      memory_data_out <= '0;
      memory_parity_out <= 8'h00;
    end else begin
      memory_data_oe_n <= memory_write_enable_n;
      memory_data_out <= mem_drive;
      memory_parity_out <= even_parity(mem_drive);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host and pci bus drive

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_data_oe_n <= 1'b1;
      host_data_out <= '0;
    end else begin
      host_data_oe_n <= 1'b0;
      case (host_command_code)
        `HC_DRVHM: host_data_out <= read_latch_r;
        `HC_RINV: host_data_out <= {56'h0, ipi_r};
        `HC_RGREG: host_data_out <= {32'h0, gp_r};
        `HC_DRVHP, `HC_DRVHPOP, `HC_DRVMP, `HC_DRVMPOP: host_data_out <= pth_mem_r[pth_front_r];
        default: begin
          host_data_oe_n <= 1'b1;
          host_data_out <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pci_ad_oe_n <= 1'b1;
      pci_ad_out <= '0;
    end else begin
      // Pci code is held across pci edges, so drive follows it as a level
      pci_ad_oe_n <= !(pci_command_code == `PC_DRVP || pci_command_code == `PC_DRVPOP);
      pci_ad_out <= pci_upper_dword_select ? read_latch_r[63:32] : read_latch_r[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence latch_close_s;
    memory_read_latch_enable ##1 !memory_read_latch_enable;
  endsequence

  a_ctm_push_rear: assert property (@(posedge sys_clk) disable iff (rst)
    host_command_code == `HC_CMPSH |=> ctm_rear_r == $past(ctm_rear_r) + 1'b1)
    else $error("push did not advance rear");
  a_ctm_pop_front: assert property (@(posedge sys_clk) disable iff (rst)
    memory_buffer_pop_strobe |=> ctm_front_r == $past(ctm_front_r) + 1'b1)
    else $error("pop did not advance front");
  a_ipi_write_value: assert property (@(posedge sys_clk) disable iff (rst)
    host_command_code == `HC_WINV ##1 host_command_code == `HC_RINV |=> host_data_out[7:0] == $past(host_data_in[7:0], 2))
    else $error("vector readback wrong");
  a_gp_write_value: assert property (@(posedge sys_clk) disable iff (rst)
    host_command_code == `HC_WGREG |=> gp_r == $past(host_data_in[31:0]))
    else $error("config write lost");
  a_mem_oe_follow: assert property (@(posedge sys_clk) disable iff (rst)
    memory_write_enable_n != $past(memory_write_enable_n) |=> memory_data_oe_n == $past(memory_write_enable_n))
    else $error("memory enable wrong");
  a_upper_dword_drive: assert property (@(posedge sys_clk) disable iff (rst)
    memory_upper_dword_select |=> memory_data_out[31:0] == $past(mem_entry[63:32]))
    else $error("upper dword not on low half");
  a_latch_hold_data: assert property (@(posedge sys_clk) disable iff (rst)
    latch_close_s ##1 !memory_read_latch_enable [*2] |-> $stable(read_latch_r))
    else $error("latch not holding");
  a_serr_on_error: assert property (@(posedge sys_clk) disable iff (rst)
    parity_err |=> !system_error_oe_n && !system_error_out)
    else $error("parity error not reported");
  a_parity_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    !gp_r[`GP_PARITY_EN_BIT] |=> system_error_oe_n)
    else $error("error reported with parity off");
  a_pci_rear_fwd: assert property (@(posedge sys_clk) disable iff (rst)
    pci_rise && pci_command_code == `PC_FDPTH |=> pth_rear_r == $past(pth_rear_r) + 1'b1)
    else $error("pci forward missed");
  a_reset_quiet: assert property (@(posedge sys_clk)
    rst |=> host_data_oe_n && memory_data_oe_n && pci_ad_oe_n && gp_r == `GP_RESET && ctm_rear_r == '0)
    else $error("reset state wrong");

endmodule : local_data_buffer_datapath

// *** testbench/far_side_model.sv ***
// Purpose: Memory devices and pci clock at the far side of the data buffer
// Assumes: Bench sets word, drive and bad_parity just after sys_clk rises
// Notes:   Pci clock runs free at a quarter of the sys_clk rate
`timescale 1ns/1ps
module far_side_model (
  input wire logic sys_clk,
  input wire logic drive,
  input wire logic bad_parity,
  input wire logic [63:0] word,
  output logic [63:0] memory_data_in,
  output logic [7:0] memory_parity_in,
  output logic pci_clock
);
  logic [1:0] div_r = 2'h0;
  logic [7:0] even_par;
  ////////////////////////////////////////////////////////////
  initial pci_clock = 1'b0;
  always @(posedge sys_clk) begin
    div_r <= div_r + 2'h1;
    pci_clock <= #1 div_r[1];
  end
  ////////////////////////////////////////////////////////////
  // Even parity per byte; a forced error flips byte 0 only
  always_comb begin
    for (int i = 0; i < 8; i++) even_par[i] = ^word[i*8 +: 8];
  end
  // Held past the latch fall; released lines show the inverse so a stale copy cannot match
  assign memory_data_in = drive ? word : ~word;
  assign memory_parity_in = drive ? (even_par ^ {7'h0, bad_parity}) : ~even_par;
endmodule : far_side_model

// *** testbench/local_data_buffer_datapath_bench.sv ***
// Purpose: Self-checking bench for the local data buffer datapath
// Assumes: DEPTH of 4; far side model supplies memory data and pci clock
// Notes:   Drivers queue expected values; a monitor compares as each bus turns on
`timescale 1ns/1ps
`include "ldb_defines.svh"
module local_data_buffer_datapath_bench;
  import ldb_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, irdy_n = 1'b1, trdy_n = 1'b1, pci_clock;
  logic [3:0] host_command_code = 4'h0;
  logic [2:0] pci_command_code = 3'h0;
  logic memory_upper_dword_select = 1'b0, pci_upper_dword_select = 1'b0;
  logic memory_read_latch_enable = 1'b0, memory_buffer_pop_strobe = 1'b0, memory_write_enable_n = 1'b1;
  logic drive = 1'b0, bad_parity = 1'b0;
  qword_type host_data_in = 64'h0, memory_data_in, memory_data_out, host_data_out, word = 64'h0, q, v;
  logic [7:0] memory_parity_in, memory_parity_out;
  dword_type pci_ad_in = 32'h0, pci_ad_out;
  logic host_data_oe_n, memory_data_oe_n, pci_ad_oe_n, system_error_out, system_error_oe_n;
  logic h_prev, m_prev, p_prev, s_prev;
  qword_type notes[$];
  qword_type w[4];
  int errors = 0, checks_done = 0;
  ////////////////////////////////////////////////////////////
  local_data_buffer_datapath #(.DEPTH(4)) dut_u (.*);
  far_side_model far_u (.*);
  always #12.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////
  task automatic summarize;
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic check(input qword_type got, input qword_type exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic take(input qword_type got);
    if (notes.size() == 0) check(got, ~got);
    else check(got, notes.pop_front());
  endtask : take
  task automatic host(input logic [3:0] c, input qword_type d);
    host_command_code = c;
    host_data_in = d;
    cyc();
    host_command_code = `HC_IDLE;
    cyc();
  endtask : host
  // Idle code means a cpu-to-memory pop; E and F draw on the pci-to-host buffer
  task automatic drain(input logic [3:0] c, input logic sel);
    host_command_code = c;
    memory_buffer_pop_strobe = (c == `HC_IDLE);
    memory_write_enable_n = 1'b0;
    memory_upper_dword_select = sel;
    cyc();
    host_command_code = `HC_IDLE;
    memory_buffer_pop_strobe = 1'b0;
    memory_write_enable_n = 1'b1;
    cyc();
  endtask : drain
  // A held-off target keeps trdy_n high, so the push must be refused
  task automatic pci(input logic [2:0] c, input logic sel, input dword_type d, input logic stall = 1'b0);
    @(posedge pci_clock);
    pci_command_code = c;
    pci_upper_dword_select = sel;
    pci_ad_in = d;
    irdy_n = 1'b0;
    trdy_n = stall;
    cyc();
    pci_command_code = `PC_IDLE;
    irdy_n = 1'b1;
    trdy_n = 1'b1;
    cyc(4);
  endtask : pci
  task automatic latch(input qword_type d, input logic bad);
    word = d;
    bad_parity = bad;
    drive = 1'b1;
    memory_read_latch_enable = 1'b1;
    cyc();
    memory_read_latch_enable = 1'b0;
    cyc();
    drive = 1'b0;
    cyc(3);
  endtask : latch
  ////////////////////////////////////////////////////////////
  // Only the turn-on of a bus is a result, so how long it stands does not matter
  always @(negedge sys_clk) begin
    if (host_data_oe_n === 1'b0 && h_prev !== 1'b0) take(host_data_out);
    if (memory_data_oe_n === 1'b0 && m_prev !== 1'b0) take(memory_data_out);
    if (pci_ad_oe_n === 1'b0 && p_prev !== 1'b0) take({32'h0, pci_ad_out});
    if (system_error_oe_n === 1'b0 && s_prev !== 1'b0) take({63'h0, system_error_out});
    h_prev = host_data_oe_n;
    m_prev = memory_data_oe_n;
    p_prev = pci_ad_oe_n;
    s_prev = system_error_oe_n;
  end
  initial begin
    #(25 * 3000);
    errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    q = $urandom(32'h89d5);
    cyc(3);
    rst = 1'b0;
    q = {$urandom, $urandom};
    v = {$urandom, $urandom};
    notes.push_back(64'h0); host(`HC_RGREG, q);
    notes.push_back(64'h0); host(`HC_RINV, q);
    host(`HC_WINV, v);
    notes.push_back({56'h0, v[7:0]}); host(`HC_RINV, q);
    host(`HC_WGREG, {32'h0, 2'b00, q[29:0]});
    notes.push_back({34'h0, q[29:0]}); host(`HC_RGREG, v);
    for (int i = 0; i < 4; i++) begin
      w[i] = {$urandom, $urandom};
      host(`HC_CMPSH, w[i]);
    end
    for (int i = 0; i < 4; i++) begin
      notes.push_back(i == 3 ? {w[i][63:32], w[i][63:32]} : w[i]);
      drain(`HC_IDLE, i == 3);
    end
    pci(`PC_PTHPSH, 1'b1, v[31:0], 1'b1);
    pci(`PC_PTHPSH, 1'b0, q[31:0]);
    pci(`PC_PTHPSH, 1'b1, q[63:32]);
    pci(`PC_MABORT, 1'b0, 32'h0);
    repeat (2) notes.push_back(q);
    drain(`HC_DRVMPOP, 1'b0);
    repeat (2) notes.push_back(64'hFFFFFFFFFFFFFFFF);
    drain(`HC_DRVMP, 1'b0);
    latch(v, 1'b1);
    notes.push_back(v); host(`HC_DRVHM, q);
    notes.push_back({32'h0, v[31:0]}); pci(`PC_DRVP, 1'b0, 32'h0);
    notes.push_back({32'h0, v[63:32]}); pci(`PC_DRVPOP, 1'b1, 32'h0);
    host(`HC_WGREG, 64'hC0000000);
    latch(q, 1'b1);
    host(`HC_WGREG, 64'h80000000);
    notes.push_back(64'h80000000); host(`HC_RGREG, v);
    notes.push_back(64'h0); latch(q, 1'b1);
    latch(v, 1'b0);
    cyc(4);
    if (notes.size() != 0) errors++;
    summarize();
  end
endmodule : local_data_buffer_datapath_bench
